//--- bpsm_top.sv
// Backup power switch, power loss flag and tamper event monitor
`include "bpsm_defines.svh"
module bpsm_top
  import bpsm_pkg::*;
#(
  parameter int unsigned HYS1_CYC = `BPSM_HYS1_US * `BPSM_CLK_MHZ,
  parameter int unsigned HYS2_CYC = `BPSM_HYS2_US * `BPSM_CLK_MHZ,
  parameter int unsigned HYS3_CYC = `BPSM_HYS3_US * `BPSM_CLK_MHZ,
  parameter int unsigned SMP2_CYC = `BPSM_SMP2_US * `BPSM_CLK_MHZ,
  parameter int unsigned SMP1_CYC = `BPSM_SMP1_US * `BPSM_CLK_MHZ,
  parameter int unsigned SMP4_CYC = `BPSM_SMP4_US * `BPSM_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`BPSM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic event_input,
  input wire logic main_below_backup_hys,
  input wire logic main_below_trip,
  input wire logic main_above_backup_hys,
  input wire logic main_above_trip_hys,
  input wire logic main_below_backup,
  input wire logic both_supplies_lost,
  input wire logic crystal_input,
  input wire logic alarm_event,
  input wire logic serial_req,
  output logic serial_enable,
  output logic on_backup,
  output logic seconds_enable,
  output logic event_detect_output_oe,
  output logic event_detect_output_o,
  output logic alarm_or_freq_pin_oe,
  output logic alarm_or_freq_pin_o
);

  // Released reset copy; async assert, sync release
  logic [1:0] rst_sync_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_q[1];

  // Three-stage sampling of pins; change taken when stages two and three agree
  function automatic logic agree3(input logic [2:0] s, input logic prev);
    agree3 = (s[1] == s[2]) ? s[2] : prev;
  endfunction
  logic [2:0] ev_s_q, xt_s_q, lb_s_q;
  logic ev_q, xt_q, lost_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s_q <= 3'b000;
      xt_s_q <= 3'b000;
      lb_s_q <= 3'b000;
      ev_q <= 1'b0;
      xt_q <= 1'b0;
      lost_q <= 1'b0;
    end else begin
      ev_s_q <= {ev_s_q[1:0], event_input};
      xt_s_q <= {xt_s_q[1:0], crystal_input};
      lb_s_q <= {lb_s_q[1:0], both_supplies_lost};
      ev_q <= agree3(ev_s_q, ev_q);
      xt_q <= agree3(xt_s_q, xt_q);
      lost_q <= agree3(lb_s_q, lost_q);
    end
  end

  // Comparator outputs; these arrive from analog, so they are synchronised
  logic [2:0] c0_q, c1_q, c2_q, c3_q, c4_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c0_q <= 3'b000;
      c1_q <= 3'b111; // Below trip until seen, so the seal holds
      c2_q <= 3'b000;
      c3_q <= 3'b000;
      c4_q <= 3'b000;
    end else begin
      c0_q <= {c0_q[1:0], main_below_backup_hys};
      c1_q <= {c1_q[1:0], main_below_trip};
      c2_q <= {c2_q[1:0], main_above_backup_hys};
      c3_q <= {c3_q[1:0], main_above_trip_hys};
      c4_q <= {c4_q[1:0], main_below_backup};
    end
  end
  wire cmp_bbh = c0_q[2] & c0_q[1];
  wire cmp_btr = c1_q[2] & c1_q[1];
  wire cmp_abh = c2_q[2] & c2_q[1];
  wire cmp_atr = c3_q[2] & c3_q[1];
  wire cmp_bb = c4_q[2] & c4_q[1];

  // Registers written by software
  logic [7:0] ctrl_q;
  logic [4:0] fout_q; // bit4 enables frequency mode, [3:0] rate
  logic [7:0] sram_q [2];
  wire wr_ctrl = reg_wr && reg_addr == `BPSM_OFF_CTRL;
  wire wr_stat = reg_wr && reg_addr == `BPSM_OFF_STAT;
  wire wr_fout = reg_wr && reg_addr == `BPSM_OFF_FOUT;
  bpsm_pwr_e pwr_q;
  wire bus_ok = pwr_q != BPSM_PWR_BATT;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `BPSM_CTL_RESET;
      fout_q <= 5'h00;
    end else begin
      if (wr_ctrl && bus_ok) begin
        ctrl_q <= reg_wdata;
      end
      if (wr_fout && bus_ok) begin
        fout_q <= reg_wdata[4:0];
      end
    end
  end

  // Scratch bytes hold through backup; only the bus path is cut
  always_ff @(posedge core_clk) begin
    if (reg_wr && bus_ok && reg_addr == `BPSM_OFF_SRAM0) begin
      sram_q[0] <= reg_wdata;
    end
    if (reg_wr && bus_ok && reg_addr == `BPSM_OFF_SRAM1) begin
      sram_q[1] <= reg_wdata;
    end
  end

  // Supply select; sealed battery until main seen once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= BPSM_PWR_UNUSED;
    end else begin
      unique case (pwr_q)
        BPSM_PWR_UNUSED: begin
          if (!cmp_btr) begin
            pwr_q <= BPSM_PWR_MAIN;
          end
        end
        BPSM_PWR_MAIN: begin
          if (ctrl_q[`BPSM_CTL_LPM] ? cmp_bb : (cmp_bbh && cmp_btr)) begin
            pwr_q <= BPSM_PWR_BATT;
          end
        end
        BPSM_PWR_BATT: begin
          if (cmp_abh || cmp_atr) begin
            pwr_q <= BPSM_PWR_MAIN;
          end
        end
        default: pwr_q <= BPSM_PWR_UNUSED;
      endcase
    end
  end

  // Total loss flag: caught after release, cleared by writing one
  logic tpl_q, tpl_init_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tpl_q <= 1'b0;
      tpl_init_q <= 1'b0;
    end else begin
      tpl_init_q <= 1'b1;
      if ((!tpl_init_q && lb_s_q[2]) || lost_q) begin
        tpl_q <= 1'b1;
      end else if (wr_stat && bus_ok && reg_wdata[`BPSM_ST_TPL]) begin
        tpl_q <= 1'b0;
      end
    end
  end

  // Event path active on main, or on backup unless battery use disabled
  wire on_batt = pwr_q == BPSM_PWR_BATT;
  wire ev_active = ctrl_q[`BPSM_CTL_EVEN] &&
    !(on_batt && ctrl_q[`BPSM_CTL_EVENT_BATTERY_MODE_DISABLE]);
  wire ev_gated = ev_active & ev_q;

  // Sample window timer: continuous, or a sample tick at chosen rate
  function automatic logic [31:0] smp_len(input logic [1:0] s);
    unique case (s)
      2'd1: smp_len = SMP4_CYC;
      2'd2: smp_len = SMP1_CYC;
      2'd3: smp_len = SMP2_CYC;
      default: smp_len = 32'h0000_0000;
    endcase
  endfunction
  function automatic logic [31:0] hys_len(input logic [1:0] s);
    unique case (s)
      2'd1: hys_len = HYS1_CYC;
      2'd2: hys_len = HYS2_CYC;
      2'd3: hys_len = HYS3_CYC;
      default: hys_len = 32'h0000_0000;
    endcase
  endfunction
  // One control bit turns sampling on and picks the quarter-hertz slot.
  // Limitation: the one and two hertz slots stay decoded for a wider
  // control field, but no bit reaches them, so software cannot pick them.
  // Trade-off: one bit keeps the control byte full without a second page.
  wire [1:0] smp_mode = {1'b0, ctrl_q[`BPSM_CTL_SMP_LO]};
  logic [31:0] smp_cnt_q;
  logic smp_win;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt_q <= 32'h0000_0000;
    end else if (smp_cnt_q >= smp_len(smp_mode)) begin
      smp_cnt_q <= 32'h0000_0000;
    end else begin
      smp_cnt_q <= smp_cnt_q + 32'h0000_0001;
    end
  end
  // Window stays open for the filter time plus one so a sample can qualify
  always_comb begin
    smp_win = (smp_mode == 2'd0) ||
      (smp_cnt_q <= hys_len(ctrl_q[`BPSM_CTL_HYS_LO +: 2]));
  end

  // Glitch filter: input must stay high for the selected time
  logic [31:0] hys_cnt_q;
  logic ev_hit;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hys_cnt_q <= 32'h0000_0000;
    end else if (!(ev_gated && smp_win)) begin
      hys_cnt_q <= 32'h0000_0000;
    end else if (!ev_hit) begin
      hys_cnt_q <= hys_cnt_q + 32'h0000_0001;
    end
  end
  always_comb begin
    ev_hit = ev_gated && smp_win &&
      (hys_cnt_q >= hys_len(ctrl_q[`BPSM_CTL_HYS_LO +: 2]));
  end

  // Sticky event flag; a new event wins over a clear
  logic evt_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= 1'b0;
    end else if (ev_hit) begin
      evt_q <= 1'b1;
    end else if (wr_stat && bus_ok && reg_wdata[`BPSM_ST_EVT]) begin
      evt_q <= 1'b0;
    end
  end

  // Alarm status, sticky, set wins over clear
  logic alm_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_q <= 1'b0;
    end else if (alarm_event && !fout_q[4]) begin
      alm_q <= 1'b1;
    end else if (wr_stat && bus_ok && reg_wdata[`BPSM_ST_ALM]) begin
      alm_q <= 1'b0;
    end
  end

  // Frequency divider from the sampled timebase: rate n halves n times
  logic [15:0] div_q;
  logic xt_d1_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
      xt_d1_q <= 1'b0;
    end else begin
      xt_d1_q <= xt_q;
      if (xt_q && !xt_d1_q) begin
        div_q <= div_q + 16'h0001;
      end
    end
  end
  wire fclk = fout_q[3:0] == 4'h0 ? xt_q : div_q[fout_q[3:0] - 4'h1];

  // Pin and control outputs, all registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_detect_output_oe <= 1'b0;
      event_detect_output_o <= 1'b0;
      alarm_or_freq_pin_oe <= 1'b0;
      alarm_or_freq_pin_o <= 1'b0;
      seconds_enable <= 1'b1;
      serial_enable <= 1'b0;
      on_backup <= 1'b0;
    end else begin
      // Pull low from event until flag clear
      event_detect_output_oe <= evt_q && ev_active &&
        ctrl_q[`BPSM_CTL_EVOUT];
      event_detect_output_o <= 1'b0;
      if (fout_q[4]) begin
        alarm_or_freq_pin_oe <= !fclk;
      end else begin
        alarm_or_freq_pin_oe <= alm_q;
      end
      alarm_or_freq_pin_o <= 1'b0;
      seconds_enable <= !(evt_q && ctrl_q[`BPSM_CTL_FRZ]);
      serial_enable <= bus_ok && serial_req;
      on_backup <= on_batt;
    end
  end

  // Read port; answer one cycle later, nothing while on backup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && bus_ok) begin
      unique case (reg_addr)
        `BPSM_OFF_CTRL: reg_rdata <= ctrl_q;
        `BPSM_OFF_STAT: reg_rdata <= {4'h0, alm_q, on_batt, tpl_q, evt_q};
        `BPSM_OFF_FOUT: reg_rdata <= {3'h0, fout_q};
        `BPSM_OFF_SRAM0: reg_rdata <= sram_q[0];
        `BPSM_OFF_SRAM1: reg_rdata <= sram_q[1];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

//--- bpsm_defines.svh
// Offsets, field positions, reset values and timing counts for the monitor
`ifndef BPSM_DEFINES_SVH
`define BPSM_DEFINES_SVH
`define BPSM_ADDR_W 4
`define BPSM_OFF_CTRL 4'h0
`define BPSM_OFF_STAT 4'h4
`define BPSM_OFF_FOUT 4'h8
`define BPSM_OFF_SRAM0 4'hC
`define BPSM_OFF_SRAM1 4'hD
// Control register fields
`define BPSM_CTL_EVEN 0
`define BPSM_CTL_EVENT_BATTERY_MODE_DISABLE 1
`define BPSM_CTL_FRZ 2
`define BPSM_CTL_EVOUT 3
`define BPSM_CTL_LPM 4
`define BPSM_CTL_HYS_LO 5
`define BPSM_CTL_SMP_LO 7
`define BPSM_CTL_RESET 8'h00
// Status register fields
`define BPSM_ST_EVT 0
`define BPSM_ST_TPL 1
`define BPSM_ST_BAT 2
`define BPSM_ST_ALM 3
// Timing, in ms figures scaled by 1000 (us) and a 250 MHz core clock
`define BPSM_CLK_MHZ 250
`define BPSM_HYS1_US 3900
`define BPSM_HYS2_US 15625
`define BPSM_HYS3_US 31250
`define BPSM_SMP2_US 500000
`define BPSM_SMP1_US 1000000
`define BPSM_SMP4_US 4000000
`endif

//--- bpsm_pkg.sv
// Types shared by the backup power switch and event monitor
package bpsm_pkg;
  typedef enum logic [1:0] {
    BPSM_PWR_UNUSED = 2'b00, // Battery sealed, never on main yet
    BPSM_PWR_MAIN = 2'b01,
    BPSM_PWR_BATT = 2'b11
  } bpsm_pwr_e;
endpackage

//--- bpsm_props.sv
// Port checker for the power switch and event monitor
module bpsm_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic event_input,
  input wire logic main_below_backup,
  input wire logic main_above_backup_hys,
  input wire logic main_above_trip_hys,
  input wire logic serial_enable,
  input wire logic on_backup,
  input wire logic seconds_enable,
  input wire logic event_detect_output_oe,
  input wire logic event_detect_output_o,
  input wire logic alarm_or_freq_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Quiet bus: no write in this or the previous cycle
  sequence s_quiet;
    !reg_wr && !$past(reg_wr);
  endsequence
  sequence s_rise_quiet;
    $rose(event_detect_output_oe) ##0 !$past(reg_wr) ##0 !$past(reg_wr, 2);
  endsequence
  property p_ev_cause;
    s_rise_quiet |-> $past(event_input, 5) || $past(event_input, 6);
  endproperty
  a_ev_cause: assert property (p_ev_cause)
    else $error("detect output rose without input");
  property p_event_detect_output_hold;
    event_detect_output_oe ##0 s_quiet |=> event_detect_output_oe;
  endproperty
  a_event_detect_output_hold: assert property (p_event_detect_output_hold)
    else $error("detect output released without clear");
  property p_frz_hold;
    !seconds_enable ##0 s_quiet |=> !seconds_enable;
  endproperty
  a_frz_hold: assert property (p_frz_hold)
    else $error("seconds resumed without clear");
  property p_ser_off;
    on_backup && $past(on_backup) |-> !serial_enable;
  endproperty
  a_ser_off: assert property (p_ser_off)
    else $error("serial enabled on backup");
  property p_rd_bat;
    reg_rd ##1 on_backup |-> reg_rdata == 8'h00;
  endproperty
  a_rd_bat: assert property (p_rd_bat)
    else $error("read answered on backup");
  property p_to_bat;
    $rose(on_backup) |-> $past(main_below_backup, 4);
  endproperty
  a_to_bat: assert property (p_to_bat)
    else $error("switched to backup with main high");
  property p_to_main;
    $fell(on_backup) |->
      $past(main_above_backup_hys, 4) || $past(main_above_trip_hys, 4);
  endproperty
  a_to_main: assert property (p_to_main)
    else $error("left backup without cause");
  property p_od_low;
    event_detect_output_o == 1'b0 && alarm_or_freq_pin_o == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain output drives high");
endmodule

//--- bpsm_partner.sv
// Tamper switch, supply comparators and free crystal source
module bpsm_partner #(
  parameter int XTAL_HALF = 5
) (
  input wire logic sw_open,
  input wire logic [15:0] vmain_mv,
  input wire logic [15:0] vbat_mv,
  output logic event_input,
  output logic main_below_backup_hys,
  output logic main_below_trip,
  output logic main_above_backup_hys,
  output logic main_above_trip_hys,
  output logic main_below_backup,
  output logic both_supplies_lost,
  output logic crystal_input
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TRIP = 2200;
  localparam int BHYS = 50;
  localparam int THYS = 30;
  // Comparators are ideal: no noise, so hysteresis is exact
  assign main_below_backup_hys = vmain_mv + BHYS < vbat_mv;
  assign main_below_trip = vmain_mv < TRIP;
  assign main_above_backup_hys = vmain_mv > vbat_mv + BHYS;
  assign main_above_trip_hys = vmain_mv > TRIP + THYS;
  assign main_below_backup = vmain_mv < vbat_mv;
  assign both_supplies_lost = vmain_mv == 0 && vbat_mv == 0;
  assign event_input = sw_open;
  // External timebase runs free, unrelated to the core clock
  initial begin
    crystal_input = 1'b0;
    forever #(XTAL_HALF) crystal_input = ~crystal_input;
  end
endmodule

//--- bpsm_top_tb.sv
// Self-checking bench for the power switch and event monitor
`include "bpsm_defines.svh"
module bpsm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, reg_wr, reg_rd, alarm_event, serial_req, sw;
  logic [3:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [7:0] sc [2];
  logic [15:0] vm, vb;
  logic [1:0] f;
  logic evi, bbh, btr, abh, ath, bbk, lost, xtal;
  logic ser_en, on_backup, sec_en, ev_oe, ev_o, af_oe, af_o;
  int failures, comparisons, i, n;
  // Crystal half period of several core cycles so no timebase edge is lost
  localparam int XH = 14;
  bpsm_partner #(.XTAL_HALF(XH)) prt (.sw_open(sw), .vmain_mv(vm),
    .vbat_mv(vb),
    .event_input(evi), .main_below_backup_hys(bbh), .main_below_trip(btr),
    .main_above_backup_hys(abh), .main_above_trip_hys(ath),
    .main_below_backup(bbk), .both_supplies_lost(lost),
    .crystal_input(xtal));
  // Short counts keep the filter and sampling runs brief
  bpsm_top #(.HYS1_CYC(8), .HYS2_CYC(16), .HYS3_CYC(32), .SMP4_CYC(64))
    dut (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_input(evi),
    .main_below_backup_hys(bbh), .main_below_trip(btr),
    .main_above_backup_hys(abh), .main_above_trip_hys(ath),
    .main_below_backup(bbk), .both_supplies_lost(lost),
    .crystal_input(xtal), .alarm_event(alarm_event),
    .serial_req(serial_req), .serial_enable(ser_en),
    .on_backup(on_backup), .seconds_enable(sec_en),
    .event_detect_output_oe(ev_oe), .event_detect_output_o(ev_o),
    .alarm_or_freq_pin_oe(af_oe), .alarm_or_freq_pin_o(af_o));
  // Clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [7:0] st(logic e, logic t, logic al);
    return {4'h0, al, 1'b0, t, e};
  endfunction
  function automatic logic sg(int k);
    return k == 0 ? ev_oe : (k == 1 ? on_backup : af_oe);
  endfunction
  // Pin toggles in 800 ns: timebase halved r times, two toggles a period
  function automatic int fexp(int r);
    return 800 / (XH << r);
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data are valid only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // Bounded wait; running out ends the run as a failure
  task automatic wt(input int k, input logic v);
    for (i = 0; i < 300 && sg(k) !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("wait_level", v, sg(k));
    if (i == 300) begin
      failures++;
      print_verdict();
    end
  endtask
  initial begin
    rst_b = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
    alarm_event = 0; serial_req = 1; sw = 0; vm = 16'h0ce4; vb = 16'h0bb8;
    failures = 0; comparisons = 0;
    void'($urandom(32'h182e_882f));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(`BPSM_OFF_CTRL, `BPSM_CTL_RESET);
    rd(4'h2, 8'h00);
    sc[0] = 8'h5a;
    sc[1] = 8'ha5;
    wr(4'hc, sc[0]);
    wr(4'hd, sc[1]);
    for (n = 0; n < 6; n++) begin
      serial_req <= 1'($urandom);
      a = 4'hc + 4'($urandom_range(1));
      d = 8'($urandom);
      wr(a, d);
      sc[a[0]] = d;
      rd(4'hc, sc[0]);
      rd(4'hd, sc[1]);
      chk("serial_enable", serial_req, ser_en);
    end
    // Disabled detection ignores a high input
    sw <= 1'b1;
    serial_req <= 1'b1;
    repeat (40) @(posedge core_clk);
    rd(`BPSM_OFF_STAT, st(0, 0, 0));
    f = 2'($urandom_range(3));
    wr(`BPSM_OFF_CTRL, {1'b0, f, 5'b0_1101});
    wt(0, 1);
    rd(`BPSM_OFF_STAT, st(1, 0, 0));
    chk("seconds_enable", 0, sec_en);
    sw <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(`BPSM_OFF_STAT, 8'h01);
    wt(0, 0);
    rd(`BPSM_OFF_STAT, st(0, 0, 0));
    chk("seconds_enable", 1, sec_en);
    // Backup: bus refused, monitor still live
    wr(`BPSM_OFF_CTRL, 8'h09);
    vm <= 16'h0834;
    wt(1, 1);
    chk("serial_enable", 0, ser_en);
    rd(`BPSM_OFF_STAT, 8'h00);
    sw <= 1'b1;
    wt(0, 1);
    sw <= 1'b0;
    vm <= 16'h0c1c;
    wt(1, 0);
    rd(`BPSM_OFF_STAT, st(1, 0, 0));
    rd(4'hd, sc[1]);
    chk("serial_enable", 1, ser_en);
    wr(`BPSM_OFF_STAT, 8'h01);
    // Sampled mode: detection only inside the periodic window
    wr(`BPSM_OFF_CTRL, 8'ha9);
    sw <= 1'b1;
    wt(0, 1);
    sw <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(`BPSM_OFF_STAT, 8'h01);
    wt(0, 0);
    // Below backup but above trip: stays on main, then goes to backup once LPM is set
    vm <= 16'h09c4;
    repeat (30) @(posedge core_clk);
    #1 chk("on_backup", 0, on_backup);
    wr(`BPSM_OFF_CTRL, 8'h10);
    wt(1, 1);
    vm <= 16'h0ce4;
    wt(1, 0);
    // Frequency mode toggles the shared pin and blocks alarms
    f = 2'($urandom_range(2));
    wr(`BPSM_OFF_FOUT, 8'h10 | 8'(f));
    alarm_event <= 1'b1;
    @(posedge core_clk);
    alarm_event <= 1'b0;
    n = 0;
    #1;
    for (i = 0; i < 200; i++) begin
      d[0] = af_oe;
      @(posedge core_clk);
      #1 n += int'(af_oe !== d[0]);
    end
    chk("fout_edges", 1, 8'(n >= fexp(f) - 2 && n <= fexp(f) + 2));
    rd(`BPSM_OFF_STAT, st(0, 0, 0));
    wr(`BPSM_OFF_FOUT, 8'h00);
    alarm_event <= 1'b1;
    @(posedge core_clk);
    alarm_event <= 1'b0;
    wt(2, 1);
    rd(`BPSM_OFF_STAT, st(0, 0, 1));
    wr(`BPSM_OFF_STAT, 8'h08);
    wt(2, 0);
    // Both supplies gone, then back
    vm <= 16'h0000;
    vb <= 16'h0000;
    repeat (10) @(posedge core_clk);
    vm <= 16'h0ce4;
    vb <= 16'h0bb8;
    rd(`BPSM_OFF_STAT, st(0, 1, 0));
    print_verdict();
  end
endmodule
bind bpsm_top bpsm_props u_props (.core_clk(core_clk), .rst_b(rst_b),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .event_input(event_input), .main_below_backup(main_below_backup),
  .main_above_backup_hys(main_above_backup_hys),
  .main_above_trip_hys(main_above_trip_hys),
  .serial_enable(serial_enable), .on_backup(on_backup),
  .seconds_enable(seconds_enable),
  .event_detect_output_oe(event_detect_output_oe),
  .event_detect_output_o(event_detect_output_o),
  .alarm_or_freq_pin_o(alarm_or_freq_pin_o));
